/* File: common/ewpt_pkg.sv */
package ewpt_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_PERIOD = 4'h4;
  localparam logic [3:0] OFS_CAPTURE = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  localparam logic [4:0] OFS_MASK = 5'h10;
  localparam logic [4:0] OFS_COUNT = 5'h14;

  // Control register field positions
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_START_LSB = 2;
  localparam int CTL_SRC_LSB = 4;
  localparam int CTL_DIVB_BIT = 6;
  localparam int CTL_ACAP_BIT = 7;
  localparam int CTL_MCAP_BIT = 8;
  localparam int CTL_WPOL_BIT = 9;

  // Status and mask bit positions
  localparam int STS_MATCH_BIT = 0;
  localparam int STS_CAPT_BIT = 1;

  // Reset values
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [9:0] CONTROL_RST = 10'h000;

  // Prescaler exponents for each source clock choice (divider base adds one)
  localparam logic [4:0] DIV_EXP0 = 5'h0B;
  localparam logic [4:0] DIV_EXP1 = 5'h07;
  localparam logic [4:0] DIV_EXP2 = 5'h03;
  localparam logic [4:0] DIV_EXP3 = 5'h00;

  // Operating modes
  typedef enum logic [1:0]
  {
    EWPT_MODE_EVENT = 2'b00,
    EWPT_MODE_WINDOW = 2'b01,
    EWPT_MODE_PULSE = 2'b10,
    EWPT_MODE_IDLE = 2'b11
  } ewpt_mode_t;

  // Start edge select: stopped, rising, falling, (both treated as rising)
  typedef enum logic [1:0]
  {
    EWPT_START_STOP = 2'b00,
    EWPT_START_RISE = 2'b01,
    EWPT_START_FALL = 2'b10,
    EWPT_START_ALT = 2'b11
  } ewpt_start_t;

  // Pulse measurement phase
  typedef enum logic [1:0]
  {
    EWPT_PH_WAIT = 2'b00,
    EWPT_PH_RUN = 2'b01,
    EWPT_PH_HOLD = 2'b10
  } ewpt_phase_t;

  // Control register contents
  typedef struct packed
  {
    logic window_negative;
    logic capture_edge_mode;
    logic auto_capture_enable;
    logic divider_base_select;
    logic [1:0] source_clock_select;
    ewpt_start_t start_edge_select;
    ewpt_mode_t mode;
  } ewpt_ctl_t;

  // Avalon-MM slave request group
  typedef struct packed
  {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } ewpt_avm_req_t;

  // Whole state of the timer
  typedef struct packed
  {
    ewpt_ctl_t ctl;
    logic [15:0] compare_period_reg;
    logic [15:0] capture_reg;
    logic [15:0] count;
    logic [1:0] status;
    logic [1:0] mask;
    logic [12:0] prescale; // Wide enough for exponent 11 plus divider base
    logic pin_q;
    logic src_q;
    ewpt_phase_t phase;
    logic first_seen;
    logic [31:0] readdata;
    logic read_done;
  } ewpt_state_t;

endpackage

/* File: verilog/ewpt_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module ewpt_timer
(
  input wire logic ref_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // External pulse source, synchronous to ref_clk
  input wire logic event_input_pin,
  // Level interrupt
  output logic timer_match_irq
);

  // Registered state and its next value
  ewpt_pkg::ewpt_state_t st;
  ewpt_pkg::ewpt_state_t next_st;
  // Bundled bus request
  ewpt_pkg::ewpt_avm_req_t req;

  // Group bus signals
  always_comb
  begin
    req.address = avs_address;
    req.read = avs_read;
    req.write = avs_write;
    req.writedata = avs_writedata;
  end

  // Reads take one wait cycle so readdata comes from a flip-flop; writes land at once
  assign avs_waitrequest = req.read && !st.read_done;
  assign avs_readdata = st.readdata;
  assign timer_match_irq = |(st.status & st.mask);

  // Main next-state logic
  always_comb
  begin
    logic [4:0] div_exp;
    logic src_lvl;
    logic src_tick;
    logic running;
    logic pin_rise;
    logic pin_fall;
    logic trig_edge;
    logic opp_edge;
    logic win_open;
    logic set_match;
    logic set_capt;
    logic rd_status;
    div_exp = 5'h00;
    src_lvl = 1'b0;
    src_tick = 1'b0;
    running = 1'b0;
    pin_rise = 1'b0;
    pin_fall = 1'b0;
    trig_edge = 1'b0;
    opp_edge = 1'b0;
    win_open = 1'b0;
    set_match = 1'b0;
    set_capt = 1'b0;
    rd_status = 1'b0;
    next_st = st;

    // Prescaler: source clock is a prescaler bit, tick on its rising edge
    unique case (st.ctl.source_clock_select)
      2'b00: div_exp = ewpt_pkg::DIV_EXP0;
      2'b01: div_exp = ewpt_pkg::DIV_EXP1;
      2'b10: div_exp = ewpt_pkg::DIV_EXP2;
      2'b11: div_exp = ewpt_pkg::DIV_EXP3;
    endcase
    // Divider base doubles the period by using the next bit up; the fastest choice goes from 1 to 4 cycles
    div_exp = div_exp + {4'h0, st.ctl.divider_base_select};
    next_st.prescale = st.prescale + 13'h0001;
    src_lvl = next_st.prescale[div_exp[3:0]];
    next_st.src_q = src_lvl;
    // Fastest choice with divider base off (exponent zero): one tick per ref_clk
    src_tick = (div_exp == 5'h00) ? 1'b1 : (src_lvl && !st.src_q);

    // Pin edges; pin is a synchronous input, held at least two cycles by the source
    next_st.pin_q = event_input_pin;
    pin_rise = event_input_pin && !st.pin_q;
    pin_fall = !event_input_pin && st.pin_q;
    running = (st.ctl.start_edge_select != ewpt_pkg::EWPT_START_STOP);
    // Falling select uses falling as trigger; rising (or both) uses rising
    trig_edge = (st.ctl.start_edge_select == ewpt_pkg::EWPT_START_FALL) ? pin_fall : pin_rise;
    opp_edge = (st.ctl.start_edge_select == ewpt_pkg::EWPT_START_FALL) ? pin_rise : pin_fall;

    if (running)
    begin
      unique case (st.ctl.mode)
        ewpt_pkg::EWPT_MODE_EVENT:
        begin
          // Count on the selected edge
          if (trig_edge)
            next_st.count = st.count + 16'h0001;
          // Match checked only at the opposite edge
          else if (opp_edge && st.count == st.compare_period_reg)
          begin
            next_st.count = 16'h0000;
            set_match = 1'b1;
          end
        end
        ewpt_pkg::EWPT_MODE_WINDOW:
        begin
          // Window open per polarity
          win_open = st.ctl.window_negative ? !event_input_pin : event_input_pin;
          // Count on each source clock tick while the window is open
          if (win_open && src_tick)
          begin
            if (st.count == st.compare_period_reg)
            begin
              next_st.count = 16'h0000;
              set_match = 1'b1;
            end
            else
              next_st.count = st.count + 16'h0001;
          end
        end
        ewpt_pkg::EWPT_MODE_PULSE:
        begin
          unique case (st.phase)
            ewpt_pkg::EWPT_PH_WAIT, ewpt_pkg::EWPT_PH_HOLD:
            begin
              // Trigger edge starts counting
              if (trig_edge)
                next_st.phase = ewpt_pkg::EWPT_PH_RUN;
            end
            ewpt_pkg::EWPT_PH_RUN:
            begin
              if (src_tick)
                next_st.count = st.count + 16'h0001;
              if (opp_edge)
              begin
                // Capture and interrupt on opposite edge
                next_st.capture_reg = st.count;
                set_capt = 1'b1;
                next_st.first_seen = 1'b1;
                // Mode bit one is single edge
                if (st.ctl.capture_edge_mode)
                begin
                  // Counter parks at one until the next trigger
                  next_st.count = 16'h0001;
                  next_st.phase = ewpt_pkg::EWPT_PH_HOLD;
                end
              end
              else if (trig_edge && !st.ctl.capture_edge_mode)
              begin
                // Double edge: full cycle captured, counter restarts
                next_st.capture_reg = st.count;
                set_capt = 1'b1;
                next_st.count = 16'h0000;
              end
            end
            default:
              next_st.phase = ewpt_pkg::EWPT_PH_WAIT;
          endcase
        end
        ewpt_pkg::EWPT_MODE_IDLE:
          next_st.count = st.count;
      endcase
      // Auto-capture outside pulse mode, each source tick
      if (st.ctl.auto_capture_enable && st.ctl.mode != ewpt_pkg::EWPT_MODE_PULSE && src_tick)
        next_st.capture_reg = st.count;
    end
    else
    begin
      // Stopped: counter cleared, pulse phase rearmed (first capture may be off)
      next_st.count = 16'h0000;
      next_st.phase = ewpt_pkg::EWPT_PH_WAIT;
      next_st.first_seen = 1'b0;
    end

    // Bus read: one wait cycle, then data stands at the completing edge
    next_st.read_done = 1'b0;
    if (req.read && !st.read_done)
    begin
      next_st.read_done = 1'b1;
      unique case (req.address)
        ewpt_pkg::OFS_CONTROL: next_st.readdata = {22'h000000, st.ctl};
        ewpt_pkg::OFS_PERIOD: next_st.readdata = {16'h0000, st.compare_period_reg};
        // Single full-width read keeps both halves coherent
        ewpt_pkg::OFS_CAPTURE: next_st.readdata = {16'h0000, st.capture_reg};
        ewpt_pkg::OFS_STATUS:
        begin
          next_st.readdata = {30'h00000000, st.status};
          rd_status = 1'b1;
        end
        ewpt_pkg::OFS_MASK: next_st.readdata = {30'h00000000, st.mask};
        ewpt_pkg::OFS_COUNT: next_st.readdata = {16'h0000, st.count};
        default: next_st.readdata = 32'h00000000;
      endcase
    end

    // Bus write, completes with no wait
    if (req.write)
    begin
      unique case (req.address)
        ewpt_pkg::OFS_CONTROL: next_st.ctl = ewpt_pkg::ewpt_ctl_t'(req.writedata[9:0]);
        ewpt_pkg::OFS_PERIOD: next_st.compare_period_reg = req.writedata[15:0];
        ewpt_pkg::OFS_MASK: next_st.mask = req.writedata[1:0];
        default: next_st.mask = st.mask;
      endcase
    end

    // Sticky status: read clears, a new event in the same cycle wins
    if (rd_status)
      next_st.status = 2'b00;
    if (set_match)
      next_st.status[ewpt_pkg::STS_MATCH_BIT] = 1'b1;
    if (set_capt)
      next_st.status[ewpt_pkg::STS_CAPT_BIT] = 1'b1;
  end

  // State register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
      st.ctl <= ewpt_pkg::ewpt_ctl_t'(ewpt_pkg::CONTROL_RST);
      st.compare_period_reg <= ewpt_pkg::PERIOD_RST;
    end
    else
      st <= next_st;
  end

endmodule

`default_nettype wire

/* File: sim/ewpt_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ewpt_src_model
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [3:0] hi_len,
  input wire logic [3:0] lo_len,
  output logic pin
);
  // Cycles spent at the present level
  logic [3:0] cnt;
  logic [3:0] want;
  logic [3:0] len;
  assign want = pin ? hi_len : lo_len;
  // Never shorter than two cycles, whatever the bench asks
  assign len = (want < 4'h2) ? 4'h2 : want;
  // Toggle once the hold is spent; the level freezes while stopped
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin <= 1'b0;
      cnt <= 4'h0;
    end
    else if (run)
    begin
      pin <= (cnt + 4'h1 >= len) ? !pin : pin;
      cnt <= (cnt + 4'h1 >= len) ? 4'h0 : cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: sim/ewpt_timer_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ewpt_timer_chk
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic event_input_pin,
  input wire logic timer_match_irq
);
  // Shadows of writable registers, pin history
  logic [15:0] per_q;
  logic [1:0] mask_q;
  logic [3:0] ctl_q;
  logic [3:0] hist;
  logic rdone;
  logic opp;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  assign rdone = avs_read && !avs_waitrequest;
  // Pin level after the edge opposite to counting
  assign opp = (ctl_q[3:2] == 2'b10);
  // Follow writes as the slave takes them
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      per_q <= ewpt_pkg::PERIOD_RST;
      mask_q <= 2'h0;
      ctl_q <= 4'h0;
      hist <= 4'h0;
    end
    else
    begin
      hist <= {hist[2:0], event_input_pin};
      if (avs_write && avs_address == {1'b0, ewpt_pkg::OFS_PERIOD})
        per_q <= avs_writedata[15:0];
      if (avs_write && avs_address == ewpt_pkg::OFS_MASK)
        mask_q <= avs_writedata[1:0];
      if (avs_write && avs_address == 5'h00)
        ctl_q <= avs_writedata[3:0];
    end
  end
  AST_WAIT_READ: assert property (avs_waitrequest |-> avs_read)
    else $error("waitrequest without read");
  AST_WAIT_FIRST: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait state wrong");
  AST_RD_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("readdata moved without read");
  AST_PERIOD_RB: assert property (rdone && avs_address == 5'h04 |-> avs_readdata == {16'h0000, per_q})
    else $error("period readback wrong");
  AST_UNMAPPED: assert property (rdone && avs_address > 5'h14 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_MASK_OFF: assert property (avs_write && avs_address == 5'h10 && avs_writedata[1:0] == 2'h0 |=> !timer_match_irq)
    else $error("masked interrupt still high");
  AST_IRQ_LEVEL: assert property (rdone && avs_address == 5'h0C |-> $past(timer_match_irq) == |(avs_readdata[1:0] & mask_q))
    else $error("interrupt level disagrees with status");
  AST_EVT_IRQ: assert property (ctl_q[1:0] == 2'b00 && mask_q == 2'b01 && $stable(mask_q) && $rose(timer_match_irq)
    |-> hist[1:0] == {!opp, opp} || hist[2:1] == {!opp, opp} || hist[3:2] == {!opp, opp})
    else $error("event match not at opposite edge");
  COV_IRQ: cover property ($rose(timer_match_irq));
  COV_STATUS: cover property (rdone && avs_address == 5'h0C && avs_readdata[1]);
  COV_MASK: cover property (avs_write && avs_address == 5'h10);
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h seen %0h", n, e, s); end end
module tb_top;
  logic ref_clk, reset_n, avs_read, avs_write, src_run, event_input_pin, timer_match_irq, avs_waitrequest, trk, prv, hit;
  logic wm, wneg;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rv;
  logic [3:0] hi_len, lo_len;
  logic [1:0] se;
  logic [15:0] per, ecnt, cap [3];
  int err_total = 0, cmp_count = 0, cyc = 0, ematch = 0;
  ewpt_timer dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .event_input_pin(event_input_pin), .timer_match_irq(timer_match_irq));
  ewpt_src_model src_u (.ref_clk(ref_clk), .reset_n(reset_n), .run(src_run), .hi_len(hi_len), .lo_len(lo_len),
    .pin(event_input_pin));
  // Expected event count: step on counting edge, clear on match at opposite edge
  function automatic logic [16:0] evt_step(logic [15:0] c, logic [15:0] p, logic up);
    if (up)
      return {1'b0, c + 16'h0001};
    return (c == p) ? 17'h10000 : {1'b0, c};
  endfunction
  // Expected window count: clear on match, else step
  function automatic logic [16:0] win_step(logic [15:0] c, logic [15:0] p);
    return (c == p) ? 17'h10000 : {1'b0, c + 16'h0001};
  endfunction
  task automatic conclude();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One Avalon-MM transfer; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do
      @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      conclude();
    end
  end
  // Pin watcher feeding the count model
  always @(posedge ref_clk)
  begin
    prv <= event_input_pin;
    if (trk && wm && event_input_pin == !wneg)
    begin
      {hit, ecnt} = win_step(ecnt, per);
      ematch += hit;
    end
    else if (trk && !wm && prv !== event_input_pin)
    begin
      {hit, ecnt} = evt_step(ecnt, per, event_input_pin == (se != 2'b10));
      ematch += hit;
    end
  end
  initial
  begin
    {reset_n, avs_read, avs_write, src_run, trk, wm, wneg} = 7'h0;
    avs_address = 5'h0;
    avs_writedata = 32'h0;
    {hi_len, lo_len} = 8'h22;
    rv = $urandom(32'h2D00);
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    bus(5'h00, 0, 0); `CHK("control", 32'h0, rv)
    bus(5'h04, 0, 0); `CHK("period", 32'hFFFF, rv)
    bus(5'h10, 0, 0); `CHK("mask", 32'h0, rv)
    bus(5'h18, 0, 0); `CHK("unmapped", 32'h0, rv)
    // Event counting, every start edge, auto-capture on
    for (int s = 1; s < 4; s++)
    begin
      per = 16'(2 + $urandom % 4);
      hi_len <= 4'(2 + $urandom % 7);
      lo_len <= 4'(2 + $urandom % 7);
      se = 2'(s);
      bus(5'h00, 1, 0);
      bus(5'h04, 1, {16'h0, per});
      bus(5'h10, 1, 1);
      bus(5'h0C, 0, 0);
      bus(5'h00, 1, {24'h0, 4'hB, se, 2'b00});
      @(posedge ref_clk);
      ecnt = 16'h0;
      ematch = 0;
      trk <= 1'b1;
      src_run <= 1'b1;
      repeat (40 + $urandom % 40) @(posedge ref_clk);
      src_run <= 1'b0;
      repeat (6) @(posedge ref_clk);
      trk <= 1'b0;
      bus(5'h14, 0, 0); `CHK("count", {16'h0, ecnt}, rv)
      bus(5'h08, 0, 0); `CHK("auto capture", {16'h0, ecnt}, rv)
      @(negedge ref_clk); `CHK("irq", ematch != 0, timer_match_irq)
      bus(5'h10, 1, 0);
      bus(5'h10, 1, 1);
      bus(5'h0C, 0, 0); `CHK("match flag", ematch != 0, rv[0])
      bus(5'h0C, 0, 0); `CHK("flag cleared", 1'b0, rv[0])
    end
    // Window counting in both polarities; idle mode freezes the count for reading
    wm = 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      per = 16'(2 + $urandom % 12);
      wneg = p[0];
      bus(5'h00, 1, 0);
      bus(5'h04, 1, {16'h0, per});
      bus(5'h0C, 0, 0);
      ecnt = 16'h0;
      ematch = 0;
      bus(5'h00, 1, {22'h0, wneg, 9'h035});
      trk <= 1'b1;
      src_run <= 1'b1;
      repeat (30 + $urandom % 40) @(posedge ref_clk);
      bus(5'h00, 1, {22'h0, wneg, 9'h037});
      trk <= 1'b0;
      src_run <= 1'b0;
      bus(5'h14, 0, 0); `CHK("window count", {16'h0, ecnt}, rv)
      bus(5'h0C, 0, 0); `CHK("window match", ematch != 0, rv[0])
    end
    wm = 1'b0;
    // Single-edge pulse width, rising trigger, source every cycle
    bus(5'h00, 1, 0);
    hi_len <= 4'(4 + $urandom % 8);
    lo_len <= 4'hF;
    bus(5'h10, 1, 3);
    bus(5'h0C, 0, 0);
    bus(5'h00, 1, 32'h136);
    src_run <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      while (timer_match_irq !== 1'b1)
        @(negedge ref_clk);
      bus(5'h08, 0, 0);
      cap[i] = rv[15:0];
      bus(5'h0C, 0, 0); `CHK("capture flag", 1'b1, rv[1])
    end
    `CHK("repeat capture", cap[1], cap[2])
    `CHK("width", 1'b1, (cap[2] + 16'h1 - 16'(hi_len)) <= 16'h3)
    conclude();
  end
endmodule
bind ewpt_timer ewpt_timer_chk chk_u (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .event_input_pin(event_input_pin), .timer_match_irq(timer_match_irq));
`default_nettype wire
